// File: src/dual_switch_spi_control.sv
// Serial command interpreter and diagnosis front end of a dual switch
// Assumes pins reach it raw; analog sensing and fault filters are outside
//
// Summary of operation
// - Chip select high ignores clock and data, serial output released.
// - Chip select fall loads diagnosis into shifter unless asleep.
// - Sample data on falling clock, shift output on rising clock.
// - Eight bit frames, most significant bit first both ways.
// - Chip select rise moves received frame into logic registers.
// - Chip select rise clears diagnosis only after a valid command.
// - Upper three bits are opcode, lower five are data.
// - Output configure bits 4 and 3 set overload mode per channel.
// - Output configure bit 2 selects restart or latch on overheat.
// - Output configure bits 1 and 0 set switching speed.
// - I/O configure bit 4 picks status pins or serial output.
// - I/O configure bits 3:2 select channel control source.
// - I/O configure bits 1:0 select first pin function.
// - Fault pin low while an error is latched, high when cleared.
// - Status pins follow input, inverted while channel has an error; pulled low while asleep.
// - Reset command restores all defaults and clears faults.
// - Asleep only wake is accepted; undervoltage also wakes.
// - Wake leaves sleep at once; ready rises only after a wake delay.
// - On/off bits 4 and 3 drive channels under serial control.
// - Entering sleep turns outputs off and clears on/off register.
// - Empty opcode changes nothing and keeps diagnosis.
// - Diagnosis-only reads and clears diagnosis, changes no setting.
// - Diagnosis holds two bits per channel, top two bits read high.
// - Invalid command is discarded, diagnosis not cleared.
// - Filtered faults latch while awake, newer error on a channel overwrites.
module dual_switch_spi_control #(
  parameter int WAKE_CYCLES = dsspi_pkg::WAKE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic parallel_input_ch1,
  input wire logic parallel_input_ch2,
  input wire logic undervoltage,
  input wire logic [1:0] faultCodeCh1,
  input wire logic faultValidCh1,
  input wire logic [1:0] faultCodeCh2,
  input wire logic faultValidCh2,
  input wire logic [1:0] extraFlags,
  output logic channelOn1,
  output logic channelOn2,
  output logic overload_mode_ch1,
  output logic overload_mode_ch2,
  output logic overTempLatch,
  output logic switch_speed_ch1,
  output logic switch_speed_ch2,
  output logic [1:0] pinOneFunction,
  output logic sleeping,
  output logic ready,
  output logic diagCleared,
  output logic pinOneOut,
  output logic pinOneOe,
  output logic pinTwoOut,
  output logic pinTwoOe
);
  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [2:0] syncA_q, syncB_q, syncA_d, syncB_d;
  logic [1:0] inA_q, inB_q;
  logic csPrev_q, sckPrev_q, csPrev_d, sckPrev_d;
  always_comb begin
    syncA_d = {csN, sclk, sdi};
    syncB_d = syncA_q;
    csPrev_d = syncB_q[2];
    sckPrev_d = syncB_q[1];
  end
  always_ff @(posedge clk) begin
    syncA_q <= syncA_d;
    syncB_q <= syncB_d;
    inA_q <= {parallel_input_ch2, parallel_input_ch1};
    inB_q <= inA_q;
    csPrev_q <= csPrev_d;
    sckPrev_q <= sckPrev_d;
  end
  logic cs, csFall, csRise, sckFall, sckRise;
  assign cs = syncB_q[2];
  assign csFall = csPrev_q & ~cs;
  assign csRise = ~csPrev_q & cs;
  assign sckFall = ~cs & sckPrev_q & ~syncB_q[1];
  assign sckRise = ~cs & ~sckPrev_q & syncB_q[1];

  function automatic logic [7:0] diagByte(input dsspi_pkg::dsspi_fault_s f,
                                          input logic [1:0] fl);
    diagByte = {dsspi_pkg::DIAG_UNUSED, fl, f.ch2, f.ch1};
  endfunction
  // ********************************************************************
  // Shifter and command state
  // ********************************************************************
  logic [7:0] rx_q, rx_d, tx_q, tx_d;
  logic [2:0] cnt_q, cnt_d;
  logic full_q, full_d;
  dsspi_pkg::dsspi_outcfg_s ocfg_q, ocfg_d;
  logic [4:0] iocfg_q, iocfg_d;
  logic [1:0] onoff_q, onoff_d;
  dsspi_pkg::dsspi_fault_s diag_q, diag_d;
  logic [1:0] flags_q, flags_d;
  logic sleep_q, sleep_d, clr_q, clr_d;
  logic [31:0] wake_q, wake_d;
  logic [2:0] op;
  logic valid;
  assign op = rx_q[dsspi_pkg::OP_MSB:dsspi_pkg::OP_LSB];
  always_comb begin
    if (sleep_q)
      valid = full_q && op == dsspi_pkg::OP_WAKE;
    else
      // empty opcode invalid; short frame invalid
      valid = full_q && op != dsspi_pkg::OP_NONE;
  end

  always_comb begin
    rx_d = rx_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    full_d = full_q;
    ocfg_d = ocfg_q;
    iocfg_d = iocfg_q;
    onoff_d = onoff_q;
    diag_d = diag_q;
    flags_d = flags_q | extraFlags;
    sleep_d = sleep_q;
    clr_d = 1'b0;
    wake_d = (wake_q != 32'h0) ? wake_q - 32'h1 : wake_q;
    if (faultValidCh1 && !sleep_q)
      diag_d.ch1 = faultCodeCh1;
    if (faultValidCh2 && !sleep_q)
      diag_d.ch2 = faultCodeCh2;
    if (csFall) begin
      if (!sleep_q)
        tx_d = diagByte(diag_q, flags_q);
      cnt_d = 3'h0;
      full_d = 1'b0;
    end else if (sckFall) begin
      // sample on falling clock; msb first
      rx_d = {rx_q[6:0], syncB_q[0]};
      cnt_d = cnt_q + 3'h1;
      if (cnt_q == dsspi_pkg::CNT_LAST)
        full_d = 1'b1;
    end else if (sckRise && cnt_q != 3'h0) begin
      // next bit out on rising clock
      tx_d = {tx_q[6:0], 1'b1};
    end
    if (csRise && valid) begin
      // clear only on valid; diag-only just clears
      diag_d = {dsspi_pkg::DIAG_OK, dsspi_pkg::DIAG_OK};
      flags_d = 2'h0;
      clr_d = 1'b1;
      unique case (op)
        dsspi_pkg::OP_OUTCFG: begin
          ocfg_d = rx_q[4:0];
        end
        dsspi_pkg::OP_IOCFG: begin
          iocfg_d = rx_q[4:0];
        end
        dsspi_pkg::OP_RESET: begin
          ocfg_d = dsspi_pkg::OUTCFG_RST;
          iocfg_d = dsspi_pkg::IOCFG_RST;
          onoff_d = dsspi_pkg::ONOFF_RST;
        end
        dsspi_pkg::OP_SLEEP: begin
          sleep_d = 1'b1;
          onoff_d = dsspi_pkg::ONOFF_RST;
        end
        dsspi_pkg::OP_WAKE: begin
          if (sleep_q) begin
            sleep_d = 1'b0;
            wake_d = WAKE_CYCLES;
          end
        end
        dsspi_pkg::OP_ONOFF: begin
          onoff_d = {rx_q[dsspi_pkg::BIT_ON2], rx_q[dsspi_pkg::BIT_ON1]};
        end
        default: begin
        end
      endcase
    end
    if (undervoltage && sleep_q) begin
      sleep_d = 1'b0;
      wake_d = WAKE_CYCLES;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_q <= 8'h00;
      tx_q <= 8'hFF;
      cnt_q <= 3'h0;
      full_q <= 1'b0;
      ocfg_q <= dsspi_pkg::OUTCFG_RST;
      iocfg_q <= dsspi_pkg::IOCFG_RST;
      onoff_q <= dsspi_pkg::ONOFF_RST;
      diag_q <= 4'hF;
      flags_q <= 2'h0;
      sleep_q <= 1'b0;
      clr_q <= 1'b0;
      wake_q <= 32'h0;
    end else begin
      rx_q <= rx_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      ocfg_q <= ocfg_d;
      iocfg_q <= iocfg_d;
      onoff_q <= onoff_d;
      diag_q <= diag_d;
      flags_q <= flags_d;
      sleep_q <= sleep_d;
      clr_q <= clr_d;
      wake_q <= wake_d;
    end
  end
  // ********************************************************************
  // Output stage and pins
  // ********************************************************************
  logic [1:0] ctl, in, on, err;
  logic spiMode, anyErr;
  assign ctl = iocfg_q[dsspi_pkg::CTL_MSB:dsspi_pkg::CTL_LSB];
  assign spiMode = iocfg_q[dsspi_pkg::BIT_DIAGSPI];
  assign in = inB_q;
  assign err = {diag_q.ch2 != dsspi_pkg::DIAG_OK,
                diag_q.ch1 != dsspi_pkg::DIAG_OK};
  assign anyErr = |err;
  always_comb begin
    unique case (ctl)
      dsspi_pkg::CTL_PAR: on = in;
      dsspi_pkg::CTL_OR: on = in | onoff_q;
      dsspi_pkg::CTL_AND: on = in & onoff_q;
      dsspi_pkg::CTL_SER: on = onoff_q;
    endcase
    if (sleep_q)
      on = 2'h0;
  end
  logic p1o_d, p1e_d, p2o_d, p2e_d;
  always_comb begin
    // Open drain: enable asserted means pulling low; serial output drives tx_q[7]
    p1o_d = 1'b0;
    p2o_d = tx_q[7];
    p2e_d = 1'b0;
    if (spiMode) begin
      p1e_d = (iocfg_q[1:0] == dsspi_pkg::FN_FAULT) && anyErr;
      // released when deselected; msb right after fall
      // Enable waits for the load so the new msb and enable rise together
      p2e_d = ~cs & ~csFall;
    end else begin
      // status follows input, inverted on error; both pins pulled low while asleep
      p1e_d = ~(in[0] ^ err[0]) | sleep_q;
      p2e_d = ~(in[1] ^ err[1]) | sleep_q;
      p2o_d = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {channelOn2, channelOn1} <= 2'h0;
      {overload_mode_ch2, overload_mode_ch1} <= 2'h0;
      overTempLatch <= 1'b0;
      {switch_speed_ch2, switch_speed_ch1} <= 2'h0;
      pinOneFunction <= 2'h0;
      sleeping <= 1'b0;
      ready <= 1'b0;
      diagCleared <= 1'b0;
      {pinOneOut, pinOneOe, pinTwoOut, pinTwoOe} <= 4'h0;
    end else begin
      {channelOn2, channelOn1} <= on;
      {overload_mode_ch2, overload_mode_ch1} <= {ocfg_q.ovl2, ocfg_q.ovl1};
      overTempLatch <= ocfg_q.otLatch;
      {switch_speed_ch2, switch_speed_ch1} <= {ocfg_q.spd2, ocfg_q.spd1};
      pinOneFunction <= iocfg_q[dsspi_pkg::FN_MSB:dsspi_pkg::FN_LSB];
      sleeping <= sleep_q;
      ready <= ~sleep_q && wake_q == 32'h0;
      diagCleared <= clr_q;
      {pinOneOut, pinOneOe, pinTwoOut, pinTwoOe} <= {p1o_d, p1e_d, p2o_d, p2e_d};
    end
  end
  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence frameCommit;
    csRise && valid;
  endsequence
  soRelease_a: assert property (@(posedge clk) disable iff (!nrst)
    (spiMode && cs) |=> !pinTwoOe)
    else $error("serial output driven while deselected");
  loadDiag_a: assert property (@(posedge clk) disable iff (!nrst)
    (csFall && !sleep_q) |=> tx_q == diagByte($past(diag_q), $past(flags_q)))
    else $error("diagnosis not loaded at select");
  sampleIn_a: assert property (@(posedge clk) disable iff (!nrst)
    (sckFall && !csFall) |=> rx_q[0] == $past(syncB_q[0]))
    else $error("serial input not sampled");
  clearValid_a: assert property (@(posedge clk) disable iff (!nrst)
    frameCommit |=> diag_q == 4'hF ##1 diagCleared)
    else $error("diagnosis not cleared");
  invalidKeep_a: assert property (@(posedge clk) disable iff (!nrst)
    (csRise && !valid) |=> !clr_q)
    else $error("diagnosis cleared on invalid frame");
  sleepIgnore_a: assert property (@(posedge clk) disable iff (!nrst)
    (sleep_q && csRise && op != dsspi_pkg::OP_WAKE && !undervoltage)
    |=> sleep_q && $stable(ocfg_q) && $stable(iocfg_q))
    else $error("command accepted while asleep");
  sleepOff_a: assert property (@(posedge clk) disable iff (!nrst)
    (frameCommit and op == dsspi_pkg::OP_SLEEP) |=> ##1 !channelOn1
    && !channelOn2 && onoff_q == 2'h0)
    else $error("sleep left outputs on");
  topHigh_a: assert property (@(posedge clk) disable iff (!nrst)
    csFall && !sleep_q |=> tx_q[7:6] == 2'h3)
    else $error("unused diagnosis bits not high");
  faultPin_a: assert property (@(posedge clk) disable iff (!nrst)
    (spiMode && iocfg_q[1:0] == 2'h0 && anyErr) [*2] |=> pinOneOe)
    else $error("fault pin not pulled low");
endmodule

// File: src/dsspi_pkg.sv
// Constants and types for the dual switch serial control block
// Assumes one 250 MHz clock; all serial pins are asynchronous to it
package dsspi_pkg;
  // ********************************************************************
  // Opcodes
  // ********************************************************************
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_DIAG = 3'h1;
  localparam logic [2:0] OP_OUTCFG = 3'h2;
  localparam logic [2:0] OP_IOCFG = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  localparam logic [2:0] OP_SLEEP = 3'h5;
  localparam logic [2:0] OP_WAKE = 3'h6;
  localparam logic [2:0] OP_ONOFF = 3'h7;
  // ********************************************************************
  // Frame layout
  // ********************************************************************
  localparam int FRAME_BITS = 8;
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 5;
  localparam int BIT_OVL2 = 4;
  localparam int BIT_OVL1 = 3;
  localparam int BIT_OTLATCH = 2;
  localparam int BIT_SPD2 = 1;
  localparam int BIT_SPD1 = 0;
  localparam int BIT_DIAGSPI = 4;
  localparam int CTL_MSB = 3;
  localparam int CTL_LSB = 2;
  localparam int FN_MSB = 1;
  localparam int FN_LSB = 0;
  localparam int BIT_ON2 = 4;
  localparam int BIT_ON1 = 3;
  // ********************************************************************
  // Reset values and codes
  // ********************************************************************
  localparam logic [4:0] OUTCFG_RST = 5'h00;
  localparam logic [4:0] IOCFG_RST = 5'h00;
  localparam logic [1:0] ONOFF_RST = 2'h0;
  localparam logic [1:0] CTL_PAR = 2'h0;
  localparam logic [1:0] CTL_OR = 2'h1;
  localparam logic [1:0] CTL_AND = 2'h2;
  localparam logic [1:0] CTL_SER = 2'h3;
  localparam logic [1:0] FN_FAULT = 2'h0;
  localparam logic [1:0] DIAG_OK = 2'h3;
  localparam logic [1:0] DIAG_UNUSED = 2'h3;
  localparam logic [2:0] CNT_LAST = 3'h7;
  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_MHZ = 250;
  localparam int WAKE_US = 100;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  typedef struct packed {
    logic [1:0] ch2;
    logic [1:0] ch1;
  } dsspi_fault_s;
  typedef struct packed {
    logic ovl2;
    logic ovl1;
    logic otLatch;
    logic spd2;
    logic spd1;
  } dsspi_outcfg_s;
endpackage

// File: bench/dsspi_master_model.sv
// Serial master model that frames commands and collects diagnosis bits
// Assumes pin two reads high when released, by an external pull-up
module dsspi_master_model (
  input wire logic clk,
  input wire logic pinTwoOut,
  input wire logic pinTwoOe,
  output logic csN,
  output logic sclk,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Idle levels
  // ****************************************************************
  // Clock stands low and data rests at its pull-down level
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // ****************************************************************
  // Frame transfer
  // ****************************************************************
  // clock low at selects
  task automatic xfer(input logic [7:0] cmd, input int nBits,
      output logic [7:0] rx);
    rx = 8'hFF;
    @(posedge clk);
    csN <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 7; i > 7 - nBits; i--) begin
      @(posedge clk);
      sclk <= 1'b1;
      sdi <= cmd[i];
      repeat (7) @(posedge clk);
      @(negedge clk);
      rx[i] = pinTwoOe ? pinTwoOut : 1'b1;
      @(posedge clk);
      sclk <= 1'b0;
      repeat (7) @(posedge clk);
    end
    @(posedge clk);
    csN <= 1'b1;
    sdi <= 1'b0;
  endtask
  task automatic noise();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      sclk <= ~sclk;
      sdi <= ~sdi;
      repeat (7) @(posedge clk);
    end
  endtask
endmodule

// File: bench/dual_switch_spi_control_test.sv
// Self-checking bench for the dual switch serial control block
// Assumes the master model on the serial pins and a short wake delay
module dual_switch_spi_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Short wake delay keeps the run brief
  localparam int WAKE_SIM = 40;
  logic clk;
  logic nrst = 1'b0;
  logic par1 = 1'b0;
  logic par2 = 1'b0;
  logic fv1 = 1'b0;
  logic fv2 = 1'b0;
  logic [1:0] fc1 = 2'h3;
  logic [1:0] fc2 = 2'h3;
  logic [1:0] xf = 2'h0;
  logic uv = 1'b0;
  logic dclr;
  int nClr = 0;
  int k;
  logic csN, sclk, sdi, on1, on2, ovl1, ovl2, otl, spd1, spd2;
  logic slp, rdy, p1o, p1e, p2o, p2e;
  logic [1:0] fn, a, b, d, f;
  logic [4:0] r, s;
  logic [7:0] rxByte, q;
  int n_mismatch = 0;
  int total_checks = 0;
  dsspi_master_model master_u (.clk(clk), .pinTwoOut(p2o),
    .pinTwoOe(p2e), .csN(csN), .sclk(sclk), .sdi(sdi));
  dual_switch_spi_control #(.WAKE_CYCLES(WAKE_SIM)) dut_u (
    .clk(clk), .nrst(nrst), .csN(csN), .sclk(sclk), .sdi(sdi),
    .parallel_input_ch1(par1), .parallel_input_ch2(par2),
    .undervoltage(uv), .faultCodeCh1(fc1), .faultValidCh1(fv1),
    .faultCodeCh2(fc2), .faultValidCh2(fv2), .extraFlags(xf),
    .channelOn1(on1), .channelOn2(on2), .overload_mode_ch1(ovl1),
    .overload_mode_ch2(ovl2), .overTempLatch(otl),
    .switch_speed_ch1(spd1), .switch_speed_ch2(spd2),
    .pinOneFunction(fn), .sleeping(slp), .ready(rdy),
    .diagCleared(dclr), .pinOneOut(p1o), .pinOneOe(p1e),
    .pinTwoOut(p2o), .pinTwoOe(p2e));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Clear pulses stand one cycle, so count them as they pass
  always @(posedge clk) begin
    if (dclr === 1'b1)
      nClr <= nClr + 1;
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] diagExp(logic [1:0] fl, logic [1:0] d2,
      logic [1:0] d1);
    return {2'h3, fl, d2, d1};
  endfunction
  function automatic logic onExp(logic [1:0] ctl, logic p, logic sb);
    case (ctl)
      dsspi_pkg::CTL_PAR: return p;
      dsspi_pkg::CTL_OR: return p | sb;
      dsspi_pkg::CTL_AND: return p & sb;
      default: return sb;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
      input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic frame(input logic [2:0] op, input logic [4:0] dat);
    master_u.xfer({op, dat}, 8, rxByte);
    repeat (12) @(posedge clk);
  endtask
  task automatic inject(input logic [1:0] c1, input logic [1:0] c2,
      input logic [1:0] v);
    @(posedge clk);
    fc1 <= c1;
    fc2 <= c2;
    fv1 <= v[0];
    fv2 <= v[1];
    @(posedge clk);
    fv1 <= 1'b0;
    fv2 <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Frames take some 600 ns each, so this leaves a wide margin
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    void'($urandom(32'hDF19));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    chk(8'({ovl2, ovl1, otl, spd2, spd1, fn}), 8'h00, "defaults");
    $display("test defaults done");
    for (int c = 0; c < 4; c++) begin
      r = 5'($urandom);
      s = 5'($urandom);
      frame(dsspi_pkg::OP_IOCFG, {1'b1, 2'(c), r[1:0]});
      frame(dsspi_pkg::OP_ONOFF, {r[4:3], 3'h0});
      @(posedge clk);
      par1 <= s[0];
      par2 <= s[1];
      repeat (10) @(posedge clk);
      chk(8'(fn), 8'(r[1:0]), "pin one function");
      chk(8'({on2, on1}), 8'({onExp(2'(c), par2, r[4]),
        onExp(2'(c), par1, r[3])}), "drive");
    end
    $display("test control done");
    repeat (4) begin
      r = 5'($urandom);
      frame(dsspi_pkg::OP_OUTCFG, r);
      master_u.noise();
      repeat (6) @(posedge clk);
      chk(8'({ovl2, ovl1, otl, spd2, spd1}), 8'(r), "outcfg");
      chk(8'(p2e), 8'h00, "output released");
    end
    $display("test outcfg done");
    frame(dsspi_pkg::OP_IOCFG, 5'h10);
    frame(dsspi_pkg::OP_DIAG, 5'h00);
    a = 2'($urandom_range(2, 0));
    b = 2'($urandom_range(2, 0));
    d = 2'($urandom_range(2, 0));
    f = 2'($urandom);
    inject(a, b, 2'h3);
    inject(d, 2'h3, 2'h1);
    xf <= f;
    repeat (3) @(posedge clk);
    xf <= 2'h0;
    repeat (4) @(posedge clk);
    chk(8'({p1o, p1e}), 8'h01, "fault pin low");
    r = {ovl2, ovl1, otl, spd2, spd1};
    frame(dsspi_pkg::OP_DIAG, 5'($urandom));
    chk(rxByte, diagExp(f, b, d), "diag byte");
    chk(8'({ovl2, ovl1, otl, spd2, spd1}), 8'(r), "diag keeps cfg");
    frame(dsspi_pkg::OP_DIAG, 5'h00);
    chk(rxByte, 8'hCF, "diag cleared");
    chk(8'(p1e), 8'h00, "fault pin high");
    $display("test diagnosis done");
    inject(2'h3, d, 2'h2);
    k = nClr;
    frame(dsspi_pkg::OP_NONE, 5'($urandom));
    chk(8'({ovl2, ovl1, otl, spd2, spd1}), 8'(r), "none keeps cfg");
    master_u.xfer({dsspi_pkg::OP_DIAG, 5'h00}, 5, q);
    repeat (12) @(posedge clk);
    chk(q, {2'h3, 2'h0, d[1], 3'h7}, "short frame out");
    frame(dsspi_pkg::OP_DIAG, 5'h00);
    chk(rxByte, diagExp(2'h0, d, 2'h3), "diag kept");
    chk(8'(nClr - k), 8'h01, "clear pulses");
    $display("test refused done");
    frame(dsspi_pkg::OP_OUTCFG, 5'h1F);
    frame(dsspi_pkg::OP_RESET, 5'($urandom));
    chk(8'({ovl2, ovl1, otl, spd2, spd1, fn}), 8'h00, "reset");
    s = 5'($urandom);
    par1 <= s[0];
    par2 <= s[1];
    repeat (10) @(posedge clk);
    chk(8'({p2e, p1e}), 8'({~s[1], ~s[0]}), "status pins");
    inject(2'h1, 2'h3, 2'h1);
    chk(8'({p2e, p1e}), 8'({~s[1], s[0]}), "status inverted");
    $display("test reset done");
    frame(dsspi_pkg::OP_IOCFG, 5'h0C);
    frame(dsspi_pkg::OP_ONOFF, 5'h18);
    chk(8'({on2, on1}), 8'h03, "serial on");
    frame(dsspi_pkg::OP_SLEEP, 5'h00);
    chk(8'({slp, rdy, on2, on1}), 8'h08, "asleep");
    frame(dsspi_pkg::OP_OUTCFG, 5'h1F);
    frame(dsspi_pkg::OP_ONOFF, 5'h18);
    chk(8'({ovl1, on2, on1}), 8'h00, "asleep ignores");
    frame(dsspi_pkg::OP_WAKE, 5'h00);
    chk(8'({slp, rdy}), 8'h00, "waking");
    repeat (2 * WAKE_SIM) @(posedge clk);
    chk(8'({slp, rdy, on2, on1}), 8'h04, "awake");
    frame(dsspi_pkg::OP_SLEEP, 5'h00);
    uv <= 1'b1;
    repeat (4) @(posedge clk);
    uv <= 1'b0;
    repeat (2 * WAKE_SIM) @(posedge clk);
    chk(8'({slp, rdy}), 8'h01, "undervoltage wake");
    $display("test sleep done");
    wrap_up();
  end
endmodule
